// [rtl/afe_pkg.sv]
// afe_pkg: register map, field positions, reset values and masks of the
// front-end control register bank.
// assumes: 9-bit registers at 3-bit addresses, 16-bit serial frames.
package afe_pkg;

   localparam int unsigned REG_W     = 9;
   localparam int unsigned ADDR_W    = 3;
   localparam int unsigned GAIN_W    = 6;
   localparam int unsigned NUM_REGS  = 8;
   localparam int unsigned CNT_W     = 5;
   localparam int unsigned SYNC_W    = 3;

   // register addresses
   localparam logic [2:0] REG_CONFIG       = 3'h0;
   localparam logic [2:0] REG_MUX          = 3'h1;
   localparam logic [2:0] REG_RED_GAIN     = 3'h2;
   localparam logic [2:0] REG_GREEN_GAIN   = 3'h3;
   localparam logic [2:0] REG_BLUE_GAIN    = 3'h4;
   localparam logic [2:0] REG_RED_OFFSET   = 3'h5;
   localparam logic [2:0] REG_GREEN_OFFSET = 3'h6;
   localparam logic [2:0] REG_BLUE_OFFSET  = 3'h7;

   // operating_config fields
   localparam int unsigned CFG_RANGE_BIT = 7;
   localparam int unsigned CFG_VREF_BIT  = 6;
   localparam int unsigned CFG_THREE_BIT = 5;
   localparam int unsigned CFG_CDS_BIT   = 4;
   localparam int unsigned CFG_CLAMP_BIT = 3;
   localparam int unsigned CFG_SLEEP_BIT = 2;

   // channel_mux_control fields
   localparam int unsigned MUX_ORDER_BIT = 7;
   localparam int unsigned MUX_RED_BIT   = 6;
   localparam int unsigned MUX_GREEN_BIT = 5;
   localparam int unsigned MUX_BLUE_BIT  = 4;

   // writable bits; all others store and read as zero
   localparam logic [8:0] REG_MASK [NUM_REGS] = '{9'h0FC, 9'h0F0, 9'h03F, 9'h03F,
                                                  9'h03F, 9'h1FF, 9'h1FF, 9'h1FF};
   localparam logic [8:0] REG_RESET [NUM_REGS] = '{9'h078, 9'h0C0, 9'h000, 9'h000,
                                                   9'h000, 9'h000, 9'h000, 9'h000};

   // serial frame: bit 0 read flag, bits 1-3 address, bits 7-15 data
   localparam logic [4:0] FRAME_RW_BIT     = 5'h00;
   localparam logic [4:0] FRAME_ADDR_LAST  = 5'h03;
   localparam logic [4:0] FRAME_DATA_FIRST = 5'h07;
   localparam logic [4:0] FRAME_LAST       = 5'h0F;
   localparam logic [4:0] FRAME_BITS       = 5'h10;

   typedef enum logic [2:0] {
      CH_RED   = 3'b001,
      CH_GREEN = 3'b010,
      CH_BLUE  = 3'b100
   } afe_chan_t;

endpackage : afe_pkg

// [rtl/afe_link_if.sv]
// afe_link_if: carries write words and read lookups between the serial
// link logic and the register core.
// assumes: write words held stable until the next frame completes.
`timescale 1ns/10ps
interface afe_link_if;
   logic       wr_toggle;
   logic [2:0] wr_addr;
   logic [8:0] wr_data;
   logic [2:0] rd_addr;
   logic [8:0] rd_data;

   modport link (output wr_toggle, output wr_addr, output wr_data,
                 output rd_addr, input rd_data);
   modport core (input wr_toggle, input wr_addr, input wr_data,
                 input rd_addr, output rd_data);
endinterface : afe_link_if

// [rtl/afe_sync.sv]
// afe_sync: two-flop synchroniser, one lane per bit.
// assumes: each input bit changes slowly relative to clk.
`timescale 1ns/10ps
module afe_sync #(
   parameter int unsigned W = 1
) (
   input  wire logic         clk,
   input  wire logic         reset,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta;

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         meta <= '0;
         q    <= '0;
      end else begin
         meta <= d;
         q    <= meta;
      end
   end
endmodule : afe_sync

// [rtl/afe_serial_link.sv]
// afe_serial_link: 3-wire serial register port on the link clock.
// assumes: link clock runs only inside frames; frame select is active low.
`timescale 1ns/10ps
module afe_serial_link
   import afe_pkg::*;
(
   input  wire logic  link_clk,
   input  wire logic  reset,
   input  wire logic  frame_n,
   input  wire logic  sdata_in,
   output logic       sdata_out,
   output logic       sdata_oe_n,
   afe_link_if.link   lk
);
   logic [4:0]  bit_cnt;
   logic [14:0] shift;
   logic        rd_flag;

   // frame end clears the frame state itself, no trailing edge needed
   wire frame_off = reset | frame_n;
   wire drive_bit = rd_flag && (bit_cnt >= FRAME_DATA_FIRST) && (bit_cnt < FRAME_BITS);
   wire [4:0] data_idx = FRAME_LAST - bit_cnt;

   always_ff @(posedge link_clk or posedge frame_off) begin
      if (frame_off) begin
         bit_cnt    <= 5'h00;
         shift      <= 15'h0000;
         rd_flag    <= 1'b0;
         lk.rd_addr <= 3'h0;
      end else if (bit_cnt < FRAME_BITS) begin
         bit_cnt <= bit_cnt + 5'h01;
         shift   <= {shift[13:0], sdata_in};
         if (bit_cnt == FRAME_RW_BIT)
            rd_flag <= sdata_in;
         if (bit_cnt == FRAME_ADDR_LAST)
            lk.rd_addr <= {shift[1:0], sdata_in};
      end
   end

   // write word is held until the next completed write frame
   always_ff @(posedge link_clk or posedge reset) begin
      if (reset) begin
         lk.wr_toggle <= 1'b0;
         lk.wr_addr   <= 3'h0;
         lk.wr_data   <= 9'h000;
      end else if (!frame_n && bit_cnt == FRAME_LAST && !rd_flag) begin
         lk.wr_toggle <= ~lk.wr_toggle;
         lk.wr_addr   <= lk.rd_addr;
         lk.wr_data   <= {shift[7:0], sdata_in};
      end
   end

   // read data launched on the falling edge, msb first
   always_ff @(negedge link_clk or posedge frame_off) begin
      if (frame_off) begin
         sdata_out  <= 1'b0;
         sdata_oe_n <= 1'b1;
      end else begin
         sdata_out  <= drive_bit ? lk.rd_data[data_idx[3:0]] : 1'b0;
         sdata_oe_n <= ~drive_bit;
      end
   end
endmodule : afe_serial_link

// [rtl/afe_ctrl_regs.sv]
// afe_ctrl_regs: control register bank and channel sequencer of a
// three-channel imaging front end, written over a 3-wire serial port.
// assumes: conversion clock and pixel strobe are asynchronous pins slower
// than clk/2; serial link clock is its own domain.
`timescale 1ns/10ps

module afe_ctrl_regs
   import afe_pkg::*;
(
   input  wire logic      clk,
   input  wire logic      reset,
   input  wire logic      serial_clk,
   input  wire logic      serial_load_n,
   input  wire logic      serial_data_in,
   output logic           serial_data_out,
   output logic           serial_data_oe_n,
   input  wire logic      conversion_clock,
   input  wire logic      pixel_sample_strobe,
   output afe_pkg::afe_chan_t channel_select,
   output logic           full_scale_4v,
   output logic           internal_ref_enable,
   output logic           channel_count_select,
   output logic           double_sampling_enable,
   output logic           clamp_bias_4v,
   output logic           sleep_enable,
   output logic [5:0]     red_gain,
   output logic [5:0]     green_gain,
   output logic [5:0]     blue_gain,
   output logic [8:0]     red_offset,
   output logic [8:0]     green_offset,
   output logic [8:0]     blue_offset
);
   import afe_pkg::*;

   afe_link_if lk ();

   logic [8:0]  regs [NUM_REGS];
   logic [2:0]  sync_q;
   logic [2:0]  sync_prev;
   afe_chan_t   next_chan;
   afe_chan_t   stepped_chan;

   afe_serial_link u_link (
      .link_clk   (serial_clk),
      .reset      (reset),
      .frame_n    (serial_load_n),
      .sdata_in   (serial_data_in),
      .sdata_out  (serial_data_out),
      .sdata_oe_n (serial_data_oe_n),
      .lk         (lk.link)
   );

   // write toggle and both timing pins cross through the same two flops
   afe_sync #(.W(SYNC_W)) u_sync (
      .clk   (clk),
      .reset (reset),
      .d     ({lk.wr_toggle, conversion_clock, pixel_sample_strobe}),
      .q     (sync_q)
   );

   always_ff @(posedge clk or posedge reset) begin
      if (reset)
         sync_prev <= 3'h0;
      else
         sync_prev <= sync_q;
   end

   // decoded events
   wire wr_take     = sync_q[2] ^ sync_prev[2];
   wire conv_fall   = sync_prev[1] & ~sync_q[1];
   wire strobe_fall = sync_prev[0] & ~sync_q[0];

   // decoded fields
   wire [8:0] cfg       = regs[REG_CONFIG];
   wire [8:0] channel_mux_control       = regs[REG_MUX];
   wire       cfg_three = cfg[CFG_THREE_BIT];
   wire       cfg_sleep = cfg[CFG_SLEEP_BIT];
   wire       order_rgb = channel_mux_control[MUX_ORDER_BIT];
   wire [8:0] wr_masked = lk.wr_data & REG_MASK[lk.wr_addr];

   // read lookup: registers only change on a completed write, so they are
   // quiet for the whole read frame that follows it
   assign lk.rd_data = regs[lk.rd_addr];

   // register file; hardware never alters it, so sleep keeps it intact
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         for (int i = 0; i < NUM_REGS; i++)
            regs[i] <= REG_RESET[i];
      end else if (wr_take) begin
         regs[lk.wr_addr] <= wr_masked;
      end
   end

   // single channel choice, red over green over blue when several are set, red when none are set
   wire [2:0] single_sel = channel_mux_control[MUX_RED_BIT]   ? CH_RED   :
                           channel_mux_control[MUX_GREEN_BIT] ? CH_GREEN :
                           channel_mux_control[MUX_BLUE_BIT]  ? CH_BLUE  : CH_RED;
   wire [2:0] first_chan = order_rgb ? CH_RED : CH_BLUE;

   always_comb begin
      case (channel_select)
         CH_RED:   stepped_chan = order_rgb ? CH_GREEN : CH_BLUE;
         CH_GREEN: stepped_chan = order_rgb ? CH_BLUE : CH_RED;
         CH_BLUE:  stepped_chan = order_rgb ? CH_RED : CH_GREEN;
         default:  stepped_chan = afe_chan_t'(first_chan);
      endcase
   end

   // strobe wins over a step in the same cycle: the new pixel starts fresh
   always_comb begin
      if (!cfg_three)
         next_chan = afe_chan_t'(single_sel);
      else if (cfg_sleep)
         next_chan = channel_select;
      else if (strobe_fall)
         next_chan = afe_chan_t'(first_chan);
      else if (conv_fall)
         next_chan = stepped_chan;
      else
         next_chan = channel_select;
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset)
         channel_select <= CH_RED;
      else
         channel_select <= next_chan;
   end

   // analog controls, one flop after the register file
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         full_scale_4v          <= REG_RESET[REG_CONFIG][CFG_RANGE_BIT];
         internal_ref_enable    <= REG_RESET[REG_CONFIG][CFG_VREF_BIT];
         channel_count_select   <= REG_RESET[REG_CONFIG][CFG_THREE_BIT];
         double_sampling_enable <= REG_RESET[REG_CONFIG][CFG_CDS_BIT];
         clamp_bias_4v          <= REG_RESET[REG_CONFIG][CFG_CLAMP_BIT];
         sleep_enable           <= REG_RESET[REG_CONFIG][CFG_SLEEP_BIT];
      end else begin
         full_scale_4v          <= cfg[CFG_RANGE_BIT];
         internal_ref_enable    <= cfg[CFG_VREF_BIT];
         channel_count_select   <= cfg_three;
         double_sampling_enable <= cfg[CFG_CDS_BIT];
         clamp_bias_4v          <= cfg[CFG_CLAMP_BIT];
         sleep_enable           <= cfg_sleep;
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         red_gain     <= 6'h00;
         green_gain   <= 6'h00;
         blue_gain    <= 6'h00;
         red_offset   <= 9'h000;
         green_offset <= 9'h000;
         blue_offset  <= 9'h000;
      end else begin
         red_gain     <= regs[REG_RED_GAIN][5:0];
         green_gain   <= regs[REG_GREEN_GAIN][5:0];
         blue_gain    <= regs[REG_BLUE_GAIN][5:0];
         red_offset   <= regs[REG_RED_OFFSET];
         green_offset <= regs[REG_GREEN_OFFSET];
         blue_offset  <= regs[REG_BLUE_OFFSET];
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   property p_cfg_zero_bits;
      cfg[8] == 1'b0 && cfg[1:0] == 2'h0 && channel_mux_control[8] == 1'b0 && channel_mux_control[3:0] == 4'h0;
   endproperty
   a_cfg_zero_bits: assert property (p_cfg_zero_bits)
      else $error("must-be-zero register bits are set");

   property p_gain_zero_bits;
      regs[REG_RED_GAIN][8:6] == 3'h0 && regs[REG_GREEN_GAIN][8:6] == 3'h0
         && regs[REG_BLUE_GAIN][8:6] == 3'h0;
   endproperty
   a_gain_zero_bits: assert property (p_gain_zero_bits)
      else $error("gain register upper bits are set");

   property p_offset_full_write;
      wr_take && lk.wr_addr >= REG_RED_OFFSET
         |=> regs[$past(lk.wr_addr)] == $past(lk.wr_data);
   endproperty
   a_offset_full_write: assert property (p_offset_full_write)
      else $error("offset write lost bits");

   property p_sleep_retain;
      cfg_sleep && !wr_take |=> $stable(regs[REG_MUX]) && $stable(regs[REG_RED_GAIN])
         && $stable(regs[REG_BLUE_OFFSET]) && $stable(cfg);
   endproperty
   a_sleep_retain: assert property (p_sleep_retain)
      else $error("register changed during sleep");

   property p_rgb_order;
      cfg_three && !cfg_sleep && order_rgb && conv_fall && !strobe_fall
         && channel_select == CH_RED |=> channel_select == CH_GREEN;
   endproperty
   a_rgb_order: assert property (p_rgb_order)
      else $error("red-green-blue sequence did not step red to green");

   property p_rgb_step;
      cfg_three && !cfg_sleep && order_rgb && conv_fall && !strobe_fall
         && channel_select == CH_GREEN |=> channel_select == CH_BLUE;
   endproperty
   a_rgb_step: assert property (p_rgb_step)
      else $error("red-green-blue sequence did not step green to blue");

   property p_bgr_step;
      cfg_three && !cfg_sleep && !order_rgb && conv_fall && !strobe_fall
         && channel_select == CH_BLUE |=> channel_select == CH_GREEN;
   endproperty
   a_bgr_step: assert property (p_bgr_step)
      else $error("blue-green-red sequence did not step blue to green");

   property p_restart;
      cfg_three && !cfg_sleep && strobe_fall
         |=> channel_select == (order_rgb ? CH_RED : CH_BLUE) || $changed(channel_mux_control);
   endproperty
   a_restart: assert property (p_restart)
      else $error("pixel strobe did not restart the sequence");

   property p_step_source;
      cfg_three && !conv_fall && !strobe_fall && $stable(cfg) |=> $stable(channel_select);
   endproperty
   a_step_source: assert property (p_step_source)
      else $error("multiplexer moved without a conversion clock edge");

   property p_single_hold;
      !cfg_three && $stable(channel_mux_control) [*3] |-> channel_select == single_sel
         && $stable(channel_select);
   endproperty
   a_single_hold: assert property (p_single_hold)
      else $error("single channel multiplexer moved");

   property p_cfg_out;
      1'b1 |=> sleep_enable == $past(cfg_sleep) && clamp_bias_4v == $past(cfg[CFG_CLAMP_BIT])
         && channel_count_select == $past(cfg_three)
         && red_offset == $past(regs[REG_RED_OFFSET]);
   endproperty
   a_cfg_out: assert property (p_cfg_out)
      else $error("control outputs do not follow registers");

   property p_rgb_wrap;
      cfg_three && !cfg_sleep && order_rgb && conv_fall && !strobe_fall
         && channel_select == CH_BLUE |=> channel_select == CH_RED;
   endproperty
   a_rgb_wrap: assert property (p_rgb_wrap)
      else $error("red-green-blue sequence did not wrap blue to red");

   property p_bgr_mid;
      cfg_three && !cfg_sleep && !order_rgb && conv_fall && !strobe_fall
         && channel_select == CH_GREEN |=> channel_select == CH_RED;
   endproperty
   a_bgr_mid: assert property (p_bgr_mid)
      else $error("blue-green-red sequence did not step green to red");

   property p_bgr_wrap;
      cfg_three && !cfg_sleep && !order_rgb && conv_fall && !strobe_fall
         && channel_select == CH_RED |=> channel_select == CH_BLUE;
   endproperty
   a_bgr_wrap: assert property (p_bgr_wrap)
      else $error("blue-green-red sequence did not wrap red to blue");

   property p_sleep_freeze;
      cfg_three && cfg_sleep |=> $stable(channel_select);
   endproperty
   a_sleep_freeze: assert property (p_sleep_freeze)
      else $error("sequence moved while sleeping");

   property p_single_select;
      !cfg_three |=> channel_select == $past(single_sel);
   endproperty
   a_single_select: assert property (p_single_select)
      else $error("single channel selection does not follow mux bits");

   property p_one_hot;
      $onehot(channel_select);
   endproperty
   a_one_hot: assert property (p_one_hot)
      else $error("channel select is not one-hot");

   property p_reg_quiet;
      !wr_take |=> $stable(cfg) && $stable(channel_mux_control) && $stable(regs[REG_RED_GAIN])
         && $stable(regs[REG_GREEN_OFFSET]);
   endproperty
   a_reg_quiet: assert property (p_reg_quiet)
      else $error("register changed without a host write");

   property p_mask_write;
      wr_take |=> regs[$past(lk.wr_addr)]
         == ($past(lk.wr_data) & REG_MASK[$past(lk.wr_addr)]);
   endproperty
   a_mask_write: assert property (p_mask_write)
      else $error("written value not stored with must-be-zero bits cleared");

   property p_gain_out;
      1'b1 |=> red_gain == $past(regs[REG_RED_GAIN][5:0])
         && green_gain == $past(regs[REG_GREEN_GAIN][5:0])
         && blue_gain == $past(regs[REG_BLUE_GAIN][5:0]);
   endproperty
   a_gain_out: assert property (p_gain_out)
      else $error("gain outputs do not follow registers");

   property p_offset_out;
      1'b1 |=> green_offset == $past(regs[REG_GREEN_OFFSET])
         && blue_offset == $past(regs[REG_BLUE_OFFSET]);
   endproperty
   a_offset_out: assert property (p_offset_out)
      else $error("offset outputs do not follow registers");

   property p_range_out;
      1'b1 |=> full_scale_4v == $past(cfg[CFG_RANGE_BIT])
         && internal_ref_enable == $past(cfg[CFG_VREF_BIT])
         && double_sampling_enable == $past(cfg[CFG_CDS_BIT]);
   endproperty
   a_range_out: assert property (p_range_out)
      else $error("range, reference or sampling outputs do not follow registers");

endmodule : afe_ctrl_regs

// [tb/afe_host_model.sv]
// afe_host_model: serial host that writes and reads the control registers.
// assumes: link clock stands low between frames; 15 ns bit period.
`timescale 1ns/10ps
module afe_host_model (
   output logic      serial_clk,
   output logic      serial_load_n,
   output logic      serial_data_in,
   input  wire logic serial_data_out,
   input  wire logic serial_data_oe_n
);
   import afe_pkg::*;

   initial begin
      serial_clk = 1'b0;
      serial_load_n = 1'b1;
      serial_data_in = 1'b0;
   end

   // read data is taken on the rising edges of frame bits 7 to 15
   task automatic frame(input logic rd, input logic [2:0] addr, input logic [8:0] data,
                        output logic [8:0] got, output logic drove);
      logic [15:0] bits;
      bits = {rd, addr, 3'h0, data};
      got = 9'h000;
      drove = 1'b1;
      serial_load_n = 1'b0;
      for (int i = 15; i >= 0; i--) begin
         serial_data_in = bits[i];
         #7.5 serial_clk = 1'b1;
         if (rd && i <= 8) begin
            got = {got[7:0], serial_data_out};
            drove = drove & (serial_data_oe_n === 1'b0);
         end
         #7.5 serial_clk = 1'b0;
      end
      #7.5 serial_load_n = 1'b1;
      // released line flips so a stale value cannot pass
      serial_data_in = ~serial_data_in;
   endtask : frame

   task automatic write_reg(input logic [2:0] addr, input logic [8:0] data, input bit raw);
      logic [8:0] unused;
      logic       d;
      if (!raw) begin
         data = data & REG_MASK[addr];
      end
      frame(1'b0, addr, data, unused, d);
   endtask : write_reg

   task automatic read_reg(input logic [2:0] addr, output logic [8:0] got,
                           output logic drove);
      frame(1'b1, addr, 9'h000, got, drove);
   endtask : read_reg
endmodule : afe_host_model

// [tb/testbench.sv]
// testbench: scenarios for the control register bank and channel sequencer.
// assumes: host model drives the serial pins; pins driven here on clk.
`timescale 1ns/10ps
module testbench;
   import afe_pkg::*;
   logic       clk, reset, conversion_clock, pixel_sample_strobe;
   logic       serial_clk, serial_load_n, serial_data_in, serial_data_out, serial_data_oe_n;
   afe_chan_t  channel_select;
   logic       full_scale_4v, internal_ref_enable, channel_count_select;
   logic       double_sampling_enable, clamp_bias_4v, sleep_enable;
   logic [5:0] red_gain, green_gain, blue_gain;
   logic [8:0] red_offset, green_offset, blue_offset;
   int         err_count, n_compared;

   afe_host_model host (.serial_clk(serial_clk), .serial_load_n(serial_load_n),
      .serial_data_in(serial_data_in), .serial_data_out(serial_data_out),
      .serial_data_oe_n(serial_data_oe_n));

   afe_ctrl_regs dut (.clk(clk), .reset(reset), .serial_clk(serial_clk),
      .serial_load_n(serial_load_n), .serial_data_in(serial_data_in),
      .serial_data_out(serial_data_out), .serial_data_oe_n(serial_data_oe_n),
      .conversion_clock(conversion_clock), .pixel_sample_strobe(pixel_sample_strobe),
      .channel_select(channel_select), .full_scale_4v(full_scale_4v),
      .internal_ref_enable(internal_ref_enable), .channel_count_select(channel_count_select),
      .double_sampling_enable(double_sampling_enable), .clamp_bias_4v(clamp_bias_4v),
      .sleep_enable(sleep_enable), .red_gain(red_gain), .green_gain(green_gain),
      .blue_gain(blue_gain), .red_offset(red_offset), .green_offset(green_offset),
      .blue_offset(blue_offset));

   initial clk = 1'b0;
   always #20 clk = ~clk;

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
      n_compared++;
      if (seen !== exp) begin
         err_count++;
         $display("unexpected at %0t: %s got %h want %h", $time, what, seen, exp);
      end
   endtask : chk

   task automatic wr(input logic [2:0] a, input logic [8:0] d, input bit raw = 1'b0);
      host.write_reg(a, d, raw);
      // write lands within 5 clk of the last link edge
      repeat (8) @(posedge clk);
      #1;
   endtask : wr

   task automatic rd_chk(input logic [2:0] a, input logic [8:0] exp);
      logic [8:0] got;
      logic       drove;
      host.read_reg(a, got, drove);
      chk(32'(drove), 32'h1, "read drive");
      chk(32'(got), 32'(exp), "read data");
      repeat (2) @(posedge clk);
   endtask : rd_chk

   task automatic pulse(input bit strobe);
      @(posedge clk);
      if (strobe) begin
         pixel_sample_strobe <= 1'b1;
      end else begin
         conversion_clock <= 1'b1;
      end
      repeat (3) @(posedge clk);
      pixel_sample_strobe <= 1'b0;
      conversion_clock <= 1'b0;
      repeat (6) @(posedge clk);
      #1;
   endtask : pulse

   task automatic chk_cfg(input logic [8:0] c);
      chk({full_scale_4v, internal_ref_enable, channel_count_select, double_sampling_enable,
           clamp_bias_4v, sleep_enable}, 32'(c[7:2]), "config");
   endtask : chk_cfg

   task automatic chk_ch(input afe_chan_t e);
      chk(32'(channel_select), 32'(e), "channel");
   endtask : chk_ch

   task automatic t_reset();
      chk_cfg(9'h078);
      chk_ch(CH_RED);
      chk({red_gain, green_gain, blue_gain}, 32'h0, "gain reset");
      chk({red_offset, green_offset, blue_offset}, 32'h0, "offset reset");
      for (int a = 0; a < 8; a++) begin
         rd_chk(3'(a), (a == 0) ? 9'h078 : (a == 1) ? 9'h0C0 : 9'h000);
      end
   endtask : t_reset

   task automatic t_config();
      wr(3'h0, 9'h084);
      chk_cfg(9'h084);
      wr(3'h0, 9'h078);
      chk_cfg(9'h078);
   endtask : t_config

   task automatic t_reserved();
      wr(3'h0, 9'h1FF, 1'b1);
      rd_chk(3'h0, 9'h0FC);
      chk_cfg(9'h0FC);
      wr(3'h0, 9'h078);
      wr(3'h1, 9'h1FF, 1'b1);
      rd_chk(3'h1, 9'h0F0);
      wr(3'h1, 9'h0C0);
      for (int a = 2; a < 8; a++) begin
         wr(3'(a), 9'h1FF, 1'b1);
         rd_chk(3'(a), (a < 5) ? 9'h03F : 9'h1FF);
      end
      chk({red_gain, green_gain, blue_gain}, 32'h3FFFF, "gain max");
      chk({red_offset, green_offset, blue_offset}, 32'h7FFFFFF, "offset max");
      wr(3'h5, 9'h100);
      chk(32'(red_offset), 32'h100, "negative zero");
      wr(3'h3, 9'h015);
      chk(32'(green_gain), 32'h15, "gain code");
   endtask : t_reserved

   task automatic run_seq(input afe_chan_t c0, input afe_chan_t c1, input afe_chan_t c2);
      afe_chan_t order [3];
      order = '{c0, c1, c2};
      pulse(1'b1);
      chk_ch(c0);
      for (int i = 1; i < 5; i++) begin
         pulse(1'b0);
         chk_ch(order[i % 3]);
      end
      pulse(1'b1);
      chk_ch(c0);
   endtask : run_seq

   task automatic t_single();
      logic [8:0] sel [3];
      afe_chan_t  ch [3];
      sel = '{9'h040, 9'h020, 9'h010};
      ch = '{CH_RED, CH_GREEN, CH_BLUE};
      wr(3'h0, 9'h058);
      for (int i = 0; i < 3; i++) begin
         wr(3'h1, sel[i]);
         chk_ch(ch[i]);
         pulse(1'b0);
         pulse(1'b1);
         pulse(1'b0);
         chk_ch(ch[i]);
      end
   endtask : t_single

   task automatic t_sleep();
      wr(3'h0, 9'h078);
      wr(3'h1, 9'h0C0);
      wr(3'h2, 9'h02A);
      pulse(1'b1);
      wr(3'h0, 9'h07C);
      chk_cfg(9'h07C);
      pulse(1'b0);
      chk_ch(CH_RED);
      chk(32'(red_gain), 32'h2A, "gain in sleep");
      rd_chk(3'h2, 9'h02A);
      rd_chk(3'h1, 9'h0C0);
      wr(3'h0, 9'h078);
      chk_cfg(9'h078);
   endtask : t_sleep

   task automatic report_and_stop();
      $display("compared %0d, mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : report_and_stop

   // sequence takes about 30 us; generous margin
   initial begin
      #400000;
      err_count++;
      report_and_stop();
   end

   initial begin
      reset = 1'b1;
      conversion_clock = 1'b0;
      pixel_sample_strobe = 1'b0;
      err_count = 0;
      n_compared = 0;
      repeat (5) @(posedge clk);
      reset <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
      t_reset();
      t_config();
      t_reserved();
      run_seq(CH_RED, CH_GREEN, CH_BLUE);
      wr(3'h1, 9'h040);
      run_seq(CH_BLUE, CH_GREEN, CH_RED);
      t_single();
      t_sleep();
      report_and_stop();
   end
endmodule : testbench
